// [shared/spm_pkg.sv]
// shared constants and types for the self-programming fuse and lock readback block
package spm_pkg;
	// ----------------------------------------
	// control register
	// ----------------------------------------
	localparam logic [7:0] CTRL_ADDR = 8'h37;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int BIT_IRQ_EN = 7;
	localparam int BIT_BUSY = 6;
	localparam int BIT_REEN = 4;
	localparam int BIT_LOCK_SET = 3;
	localparam int BIT_PG_WRITE = 2;
	localparam int BIT_PG_ERASE = 1;
	localparam int BIT_STORE_EN = 0;
	localparam logic [4:0] CMD_REEN = 5'h11;
	localparam logic [4:0] CMD_LOCK = 5'h09;
	localparam logic [4:0] CMD_WRITE = 5'h05;
	localparam logic [4:0] CMD_ERASE = 5'h03;
	localparam logic [4:0] CMD_FILL = 5'h01;
	// ----------------------------------------
	// readback pointer values
	// ----------------------------------------
	localparam logic [15:0] PTR_FUSE_LOW = 16'h0000;
	localparam logic [15:0] PTR_LOCK = 16'h0001;
	localparam logic [15:0] PTR_FUSE_EXT = 16'h0002;
	localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;
	// ----------------------------------------
	// windows and timing
	// ----------------------------------------
	localparam int LOAD_WINDOW = 3;
	localparam int STORE_WINDOW = 4;
	localparam int CLK_HZ = 10_000_000;
	localparam int WRITE_MIN_US = 3700;
	localparam int WRITE_MAX_US = 4500;
	localparam int WRITE_MIN_CYC = (WRITE_MIN_US * (CLK_HZ / 1_000_000));
	localparam int WRITE_MAX_CYC = (WRITE_MAX_US * (CLK_HZ / 1_000_000));
	localparam int WRITE_CYC = (WRITE_MIN_CYC + WRITE_MAX_CYC) / 2;
	// ----------------------------------------
	// flash geometry
	// ----------------------------------------
	localparam int BOOT_PAGES_11 = 4;
	localparam int BOOT_PAGES_10 = 8;
	localparam int BOOT_PAGES_01 = 16;
	localparam int BOOT_PAGES_00 = 32;
	localparam int BLOCKING_PAGES = 32;
	localparam int CONCURRENT_PAGES = 224;
	localparam logic [7:0] LOCK_UNUSED = 8'hC0;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_ARMED = 4'h2,
		ST_WRITING = 4'h4,
		ST_DONE = 4'h8
	} spm_state_t;
endpackage

// [shared/spm_if.sv]
// interface between the cpu core and the self-programming logic
`timescale 1ns/1ns
interface spm_if;
	logic io_wr;
	logic [7:0] io_addr;
	logic [7:0] io_wdata;
	logic [7:0] ctrl_rdata;
	logic [15:0] ptr;
	logic lpm_req;
	logic [7:0] flash_byte;
	logic [7:0] lpm_data;
	logic spm_req;
	logic [7:0] r0_data;
	logic cpu_halt;
	modport device (input io_wr, io_addr, io_wdata, ptr, lpm_req, flash_byte, spm_req, r0_data,
		output ctrl_rdata, lpm_data, cpu_halt);
	modport cpu (output io_wr, io_addr, io_wdata, ptr, lpm_req, flash_byte, spm_req, r0_data,
		input ctrl_rdata, lpm_data, cpu_halt);
endinterface

// [rtl/spm_window.sv]
// window counter: loads length on start, counts down, flags expiry
`timescale 1ns/1ns
module spm_window #(
	parameter int WIDTH = 3
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// control
	input wire logic start,
	input wire logic stop,
	input wire logic [WIDTH-1:0] length,
	// status
	output logic open,
	output logic expired
);
	logic [WIDTH-1:0] cnt_ff;
	logic [WIDTH-1:0] nxt_cnt;
	assign nxt_cnt = start ? length : (stop ? '0 : (cnt_ff != '0 ? cnt_ff - 1'b1 : '0));
	assign open = (cnt_ff != '0);
	assign expired = (cnt_ff == {{(WIDTH-1){1'b0}}, 1'b1}) && !start && !stop;
	// ----------------------------------------
	// counter
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end
endmodule

// [rtl/spm_device.sv]
// self-programming control, fuse and lock readback and flash address decode
`timescale 1ns/1ns
module spm_device #(
	parameter int PC_BITS = 14,
	parameter int WORD_BITS = 6,
	parameter int WRITE_CYCLES = spm_pkg::WRITE_CYC
) (
	// cpu side
	spm_if.device cpu,
	// nonvolatile bits, 0 means programmed
	input wire logic [5:0] lock_bits,
	input wire logic [7:0] fuse_low_byte,
	input wire logic [7:0] fuse_high_byte,
	input wire logic [7:0] fuse_extended_byte,
	input wire logic boot_size_sel_1,
	input wire logic boot_size_sel_0,
	input wire logic eeprom_write_busy,
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// flash operation outputs
	output logic flash_erase_go,
	output logic flash_write_go,
	output logic flash_fill_go,
	output logic lock_write_go,
	output logic [7:0] lock_write_data,
	output logic [PC_BITS-WORD_BITS-1:0] page_number_field,
	output logic [WORD_BITS-1:0] word_in_page_field,
	output logic [PC_BITS-1:0] boot_start_addr,
	output logic in_blocking_region
);
	initial begin
		if (PC_BITS != 14 && PC_BITS != 15) $error("PC_BITS must be 14 or 15");
		if (WORD_BITS != 6 && WORD_BITS != 7) $error("WORD_BITS must be 6 or 7");
		if (WRITE_CYCLES < 2) $error("WRITE_CYCLES too small");
	end
	localparam int counter_top_bit = PC_BITS - 1;
	localparam int word_field_top_bit = WORD_BITS - 1;
	localparam int pointer_counter_top_bit = counter_top_bit + 1;
	localparam int pointer_word_top_bit = word_field_top_bit + 1;
	localparam int PAGE_BITS = PC_BITS - WORD_BITS;
	// ----------------------------------------
	// registers
	// ----------------------------------------
	spm_pkg::spm_state_t state_ff;
	spm_pkg::spm_state_t nxt_state;
	logic [7:0] ctrl_ff;
	logic [22:0] timer_ff;
	logic [7:0] lpm_data_ff;
	logic [7:0] ctrl_rdata_ff;
	logic halt_ff;
	logic erase_ff, write_ff, fill_ff, lockw_ff;
	logic [7:0] lockw_data_ff;
	logic [PAGE_BITS-1:0] page_ff;
	logic [WORD_BITS-1:0] word_ff;
	logic [PC_BITS-1:0] boot_ff;
	logic blocking_ff;
	logic busy_ff;
	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire ctrl_wr = cpu.io_wr && (cpu.io_addr == spm_pkg::CTRL_ADDR) && !eeprom_write_busy;
	wire [4:0] cmd = cpu.io_wdata[4:0];
	wire cmd_ok = (cmd == spm_pkg::CMD_REEN) || (cmd == spm_pkg::CMD_LOCK) ||
		(cmd == spm_pkg::CMD_WRITE) || (cmd == spm_pkg::CMD_ERASE) ||
		(cmd == spm_pkg::CMD_FILL);
	wire idle = (state_ff == spm_pkg::ST_IDLE);
	wire take_cmd = ctrl_wr && cmd_ok && idle;
	wire lock_pair = ctrl_ff[spm_pkg::BIT_LOCK_SET] && ctrl_ff[spm_pkg::BIT_STORE_EN];
	wire armed = (state_ff == spm_pkg::ST_ARMED);
	wire load_open, load_exp, store_open, store_exp;
	wire readback = armed && lock_pair && load_open && cpu.lpm_req;
	wire do_store = armed && store_open && cpu.spm_req;
	wire long_op = ctrl_ff[spm_pkg::BIT_PG_WRITE] || ctrl_ff[spm_pkg::BIT_PG_ERASE];
	// command bits drop as the operation ends, so the cpu sees them clear promptly
	wire pair_drop = (nxt_state == spm_pkg::ST_DONE) || (nxt_state == spm_pkg::ST_IDLE);
	wire [PAGE_BITS-1:0] ptr_page = cpu.ptr[pointer_counter_top_bit:pointer_word_top_bit+1];
	wire [WORD_BITS-1:0] ptr_word = cpu.ptr[pointer_word_top_bit:1];
	wire [7:0] lock_byte = {2'b11, lock_bits};
	wire [7:0] fuse_sel = (cpu.ptr == spm_pkg::PTR_LOCK) ? lock_byte :
		(cpu.ptr == spm_pkg::PTR_FUSE_LOW) ? fuse_low_byte :
		(cpu.ptr == spm_pkg::PTR_FUSE_HIGH) ? fuse_high_byte :
		(cpu.ptr == spm_pkg::PTR_FUSE_EXT) ? fuse_extended_byte :
		cpu.flash_byte;
	// raw bits pass through untouched, so programmed reads 0
	wire [7:0] nxt_lpm = readback ? fuse_sel : cpu.flash_byte;
	wire [1:0] bsz = {boot_size_sel_1, boot_size_sel_0};
	wire [7:0] boot_pages = (bsz == 2'b11) ? 8'(spm_pkg::BOOT_PAGES_11) :
		(bsz == 2'b10) ? 8'(spm_pkg::BOOT_PAGES_10) :
		(bsz == 2'b01) ? 8'(spm_pkg::BOOT_PAGES_01) : 8'(spm_pkg::BOOT_PAGES_00);
	wire [PC_BITS:0] flash_words = (PC_BITS+1)'(1) << PC_BITS;
	wire [PC_BITS:0] boot_words = (PC_BITS+1)'(boot_pages) << WORD_BITS;
	wire [PC_BITS:0] blocking_region_words = (PC_BITS+1)'(spm_pkg::BLOCKING_PAGES) << WORD_BITS;
	wire [PC_BITS-1:0] nxt_boot = PC_BITS'(flash_words - boot_words);
	wire [PC_BITS-1:0] blocking_region_start = PC_BITS'(flash_words - blocking_region_words);
	wire [PC_BITS-1:0] ptr_pc = cpu.ptr[pointer_counter_top_bit:1];
	wire op_blocking = (ptr_pc >= blocking_region_start);
	// ----------------------------------------
	// windows, counted from the cycle after the write
	// ----------------------------------------
	spm_window #(.WIDTH(3)) u_load (
		.ref_clk(ref_clk),
		.srst(srst),
		.start(take_cmd),
		.stop(readback || do_store),
		.length(3'(spm_pkg::LOAD_WINDOW)),
		.open(load_open),
		.expired(load_exp)
	);
	spm_window #(.WIDTH(3)) u_store (
		.ref_clk(ref_clk),
		.srst(srst),
		.start(take_cmd),
		.stop(readback || do_store),
		.length(3'(spm_pkg::STORE_WINDOW)),
		.open(store_open),
		.expired(store_exp)
	);
	// ----------------------------------------
	// state machine
	// ----------------------------------------
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			spm_pkg::ST_IDLE: begin
				if (take_cmd) nxt_state = spm_pkg::ST_ARMED;
			end
			spm_pkg::ST_ARMED: begin
				if (readback) nxt_state = spm_pkg::ST_DONE;
				else if (do_store && (long_op || ctrl_ff[spm_pkg::BIT_LOCK_SET]))
					nxt_state = spm_pkg::ST_WRITING;
				else if (do_store) nxt_state = spm_pkg::ST_DONE;
				else if (store_exp || (lock_pair && load_exp && !store_open))
					nxt_state = spm_pkg::ST_DONE;
				else if (!store_open) nxt_state = spm_pkg::ST_DONE;
			end
			spm_pkg::ST_WRITING: begin
				if (timer_ff == 23'h000001) nxt_state = spm_pkg::ST_DONE;
			end
			spm_pkg::ST_DONE: nxt_state = spm_pkg::ST_IDLE;
			default: nxt_state = spm_pkg::ST_IDLE;
		endcase
	end
	// ----------------------------------------
	// control and timer; a running write ignores reset
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst && state_ff != spm_pkg::ST_WRITING) begin
			state_ff <= spm_pkg::ST_IDLE;
			ctrl_ff <= spm_pkg::CTRL_RESET;
			timer_ff <= '0;
			busy_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			if (take_cmd) ctrl_ff <= {cpu.io_wdata[7], 2'b00, cmd};
			else if (pair_drop) ctrl_ff[4:0] <= 5'h00;
			if (do_store && (long_op || ctrl_ff[spm_pkg::BIT_LOCK_SET]))
				timer_ff <= 23'(WRITE_CYCLES);
			else if (timer_ff != '0) timer_ff <= timer_ff - 23'h000001;
			if (do_store && long_op && !op_blocking) busy_ff <= 1'b1;
			else if (do_store && ctrl_ff[spm_pkg::BIT_REEN]) busy_ff <= 1'b0;
			else if (do_store && ctrl_ff[4:0] == spm_pkg::CMD_FILL) busy_ff <= 1'b0;
		end
	end
	// ----------------------------------------
	// registered outputs
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			lpm_data_ff <= 8'h00;
			ctrl_rdata_ff <= 8'h00;
			halt_ff <= 1'b0;
			erase_ff <= 1'b0;
			write_ff <= 1'b0;
			fill_ff <= 1'b0;
			lockw_ff <= 1'b0;
			lockw_data_ff <= 8'h00;
			page_ff <= '0;
			word_ff <= '0;
			boot_ff <= '0;
			blocking_ff <= 1'b0;
		end else begin
			lpm_data_ff <= nxt_lpm;
			ctrl_rdata_ff <= {ctrl_ff[7], busy_ff, 1'b0, ctrl_ff[4:0]};
			halt_ff <= (state_ff == spm_pkg::ST_WRITING) && long_op && blocking_ff;
			erase_ff <= do_store && ctrl_ff[4:0] == spm_pkg::CMD_ERASE;
			write_ff <= do_store && ctrl_ff[4:0] == spm_pkg::CMD_WRITE;
			fill_ff <= do_store && ctrl_ff[4:0] == spm_pkg::CMD_FILL;
			lockw_ff <= do_store && ctrl_ff[4:0] == spm_pkg::CMD_LOCK;
			lockw_data_ff <= cpu.r0_data | spm_pkg::LOCK_UNUSED;
			if (do_store) begin
				page_ff <= ptr_page;
				word_ff <= ptr_word;
				blocking_ff <= op_blocking;
			end
			boot_ff <= nxt_boot;
		end
	end
	assign cpu.lpm_data = lpm_data_ff;
	assign cpu.ctrl_rdata = ctrl_rdata_ff;
	assign cpu.cpu_halt = halt_ff;
	assign flash_erase_go = erase_ff;
	assign flash_write_go = write_ff;
	assign flash_fill_go = fill_ff;
	assign lock_write_go = lockw_ff;
	assign lock_write_data = lockw_data_ff;
	assign page_number_field = page_ff;
	assign word_in_page_field = word_ff;
	assign boot_start_addr = boot_ff;
	assign in_blocking_region = blocking_ff;
endmodule

// [rtl/spm_cpu.sv]
// cpu-side end: issues control write then load or store
`timescale 1ns/1ns
module spm_cpu (
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// user request
	input wire logic req_valid,
	input wire logic req_is_store,
	input wire logic [7:0] req_ctrl,
	input wire logic [15:0] req_ptr,
	input wire logic [7:0] req_r0,
	input wire logic [7:0] flash_byte,
	// user answer
	output logic req_busy,
	output logic ans_valid,
	output logic [7:0] ans_data,
	// link
	spm_if.cpu dev
);
	typedef enum logic [4:0] {
		C_IDLE = 5'h01,
		C_WAIT = 5'h02,
		C_CMD = 5'h04,
		C_RESP = 5'h08,
		C_ANS = 5'h10
	} cpu_state_t;
	cpu_state_t st_ff;
	logic [7:0] ctrl_ff, r0_ff, ans_ff;
	logic [15:0] ptr_ff;
	logic store_ff, wr_ff, lpm_ff, spm_ff, ans_v_ff, busy_ff;
	wire dev_idle = !dev.ctrl_rdata[spm_pkg::BIT_STORE_EN];
	// ----------------------------------------
	// sequencer: write control, then the instruction next cycle
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_ff <= C_IDLE;
			ctrl_ff <= 8'h00;
			r0_ff <= 8'h00;
			ptr_ff <= 16'h0000;
			store_ff <= 1'b0;
			wr_ff <= 1'b0;
			lpm_ff <= 1'b0;
			spm_ff <= 1'b0;
			ans_v_ff <= 1'b0;
			ans_ff <= 8'h00;
			busy_ff <= 1'b0;
		end else begin
			wr_ff <= 1'b0;
			lpm_ff <= 1'b0;
			spm_ff <= 1'b0;
			ans_v_ff <= 1'b0;
			case (st_ff)
				C_IDLE: begin
					if (req_valid) begin
						ctrl_ff <= req_ctrl;
						ptr_ff <= {req_ptr[15:1], req_ptr[0] & !req_is_store};
						r0_ff <= req_r0;
						store_ff <= req_is_store;
						busy_ff <= 1'b1;
						st_ff <= C_WAIT;
					end
				end
				C_WAIT: begin
					if (dev_idle) begin
						wr_ff <= 1'b1;
						st_ff <= C_CMD;
					end
				end
				C_CMD: begin
					lpm_ff <= !store_ff;
					spm_ff <= store_ff;
					st_ff <= C_RESP;
				end
				// load result is registered one cycle after the request
				C_RESP: begin
					st_ff <= C_ANS;
				end
				C_ANS: begin
					ans_v_ff <= !store_ff;
					ans_ff <= dev.lpm_data;
					busy_ff <= 1'b0;
					st_ff <= C_IDLE;
				end
				default: st_ff <= C_IDLE;
			endcase
		end
	end
	assign dev.io_wr = wr_ff;
	assign dev.io_addr = spm_pkg::CTRL_ADDR;
	assign dev.io_wdata = ctrl_ff;
	assign dev.ptr = ptr_ff;
	assign dev.lpm_req = lpm_ff;
	assign dev.spm_req = spm_ff;
	assign dev.r0_data = r0_ff;
	assign dev.flash_byte = flash_byte;
	assign req_busy = busy_ff;
	assign ans_valid = ans_v_ff;
	assign ans_data = ans_ff;
endmodule

// [tb/spm_monitor.sv]
// checker for the link between the cpu end and the device end
`timescale 1ns/1ns
module spm_monitor (
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// link
	input wire logic io_wr,
	input wire logic [7:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic [7:0] ctrl_rdata,
	input wire logic [15:0] ptr,
	input wire logic lpm_req,
	input wire logic [7:0] flash_byte,
	input wire logic [7:0] lpm_data,
	input wire logic spm_req,
	// nonvolatile inputs of the device
	input wire logic [5:0] lock_bits,
	input wire logic [7:0] fuse_low_byte,
	input wire logic [7:0] fuse_high_byte,
	input wire logic [7:0] fuse_extended_byte,
	input wire logic eeprom_write_busy
);
	// ----
	// load window tracker
	// ----
	logic [2:0] win_ff;
	logic [2:0] nxt_win;
	wire ctrl_hit = io_wr && io_addr == spm_pkg::CTRL_ADDR;
	wire idle = ctrl_rdata[4:0] == 5'h00;
	wire arm_hit = ctrl_hit && io_wdata[4:0] == spm_pkg::CMD_LOCK && !eeprom_write_busy && idle;
	wire armed = win_ff != 3'h0;
	wire rd_hit = lpm_req && armed;
	wire good_pat = io_wdata[4:0] inside {spm_pkg::CMD_REEN, spm_pkg::CMD_LOCK,
		spm_pkg::CMD_WRITE, spm_pkg::CMD_ERASE, spm_pkg::CMD_FILL};
	wire cmd_hit = ctrl_hit && good_pat && !eeprom_write_busy && idle;
	// window opens after the write edge and closes after three cycles or a load
	assign nxt_win = arm_hit ? 3'h1 : (lpm_req || win_ff == 3'h3 || !armed) ? 3'h0 : win_ff + 3'h1;
	// window register
	always_ff @(posedge ref_clk) begin
		win_ff <= srst ? 3'h0 : nxt_win;
	end
	// ----
	// assertions
	// ----
	default clocking mon_clk @(posedge ref_clk); endclocking
	default disable iff (srst);
	sequence s_armed_load;
		arm_hit ##[1:3] lpm_req;
	endsequence
	sequence s_armed_idle;
		cmd_hit ##1 (!spm_req) [*4];
	endsequence
	chk_lock_read: assert property (rd_hit && ptr == spm_pkg::PTR_LOCK |=>
		lpm_data == (spm_pkg::LOCK_UNUSED | {2'b00, lock_bits}))
		else $error("lock readback wrong");
	chk_fuse_low: assert property (rd_hit && ptr == spm_pkg::PTR_FUSE_LOW |=>
		lpm_data == fuse_low_byte) else $error("low fuse readback wrong");
	chk_fuse_ext: assert property (rd_hit && ptr == spm_pkg::PTR_FUSE_EXT |=>
		lpm_data == fuse_extended_byte) else $error("extended fuse readback wrong");
	chk_fuse_high: assert property (rd_hit && ptr == spm_pkg::PTR_FUSE_HIGH |=>
		lpm_data == fuse_high_byte) else $error("high fuse readback wrong");
	chk_plain_read: assert property (lpm_req && !armed |=>
		lpm_data == $past(flash_byte)) else $error("plain load not flash byte");
	chk_pair_clear: assert property (s_armed_load |-> ##[1:3] ctrl_rdata[3:0] == 4'h0)
		else $error("pair not cleared after readback");
	chk_window_end: assert property (s_armed_idle |-> ##[0:2] ctrl_rdata[3:0] == 4'h0)
		else $error("pair not cleared at window end");
	chk_reset_zero: assert property ($fell(srst) |-> ctrl_rdata == spm_pkg::CTRL_RESET)
		else $error("control not zero after reset");
	chk_reserved_zero: assert property (ctrl_rdata[5] == 1'b0)
		else $error("reserved control bit set");
	chk_bad_pattern: assert property (ctrl_hit && !good_pat && idle |->
		##2 ctrl_rdata[4:0] == 5'h00) else $error("invalid pattern took effect");
endmodule

// [tb/test_self_prog_fuse_lock_readback.sv]
// self-checking bench joining the cpu end and the device end
`timescale 1ns/1ns
module test_self_prog_fuse_lock_readback;
	// ----
	// stimulus and observed signals
	// ----
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic req_valid = 1'b0;
	logic req_is_store = 1'b0;
	logic [7:0] req_ctrl = 8'h00;
	logic [15:0] req_ptr = 16'h0000;
	logic [7:0] req_r0 = 8'h00;
	logic [7:0] flash_byte = 8'h5C;
	logic [5:0] lock_bits = 6'h2A;
	logic [7:0] fuse_low_byte = 8'hA5;
	logic [7:0] fuse_high_byte = 8'h3C;
	logic [7:0] fuse_extended_byte = 8'hF6;
	logic boot_size_sel_1 = 1'b1;
	logic boot_size_sel_0 = 1'b1;
	logic eeprom_write_busy = 1'b0;
	logic req_busy, ans_valid, in_blocking_region;
	logic flash_erase_go, flash_write_go, flash_fill_go, lock_write_go;
	logic [7:0] ans_data, lock_write_data, page_number_field, got;
	logic [5:0] word_in_page_field;
	logic [13:0] boot_start_addr;
	logic [3:0] go_seen = 4'h0;
	int failures = 0;
	int num_checks = 0;
	int cycles = 0;
	int busy_cyc = 0;
	spm_if link();
	// ----
	// the two ends and the checker
	// ----
	spm_device #(.PC_BITS(14), .WORD_BITS(6), .WRITE_CYCLES(8)) spm_device_inst (.cpu(link.device),
		.lock_bits(lock_bits), .fuse_low_byte(fuse_low_byte), .fuse_high_byte(fuse_high_byte),
		.fuse_extended_byte(fuse_extended_byte), .boot_size_sel_1(boot_size_sel_1),
		.boot_size_sel_0(boot_size_sel_0), .eeprom_write_busy(eeprom_write_busy),
		.ref_clk(ref_clk), .srst(srst), .flash_erase_go(flash_erase_go),
		.flash_write_go(flash_write_go), .flash_fill_go(flash_fill_go),
		.lock_write_go(lock_write_go), .lock_write_data(lock_write_data),
		.page_number_field(page_number_field), .word_in_page_field(word_in_page_field),
		.boot_start_addr(boot_start_addr), .in_blocking_region(in_blocking_region));
	spm_cpu spm_cpu_inst (.ref_clk(ref_clk), .srst(srst), .req_valid(req_valid),
		.req_is_store(req_is_store), .req_ctrl(req_ctrl), .req_ptr(req_ptr), .req_r0(req_r0),
		.flash_byte(flash_byte), .req_busy(req_busy), .ans_valid(ans_valid),
		.ans_data(ans_data), .dev(link.cpu));
	spm_monitor spm_monitor_inst (.ref_clk(ref_clk), .srst(srst), .io_wr(link.io_wr),
		.io_addr(link.io_addr), .io_wdata(link.io_wdata), .ctrl_rdata(link.ctrl_rdata),
		.ptr(link.ptr), .lpm_req(link.lpm_req), .flash_byte(link.flash_byte),
		.lpm_data(link.lpm_data), .spm_req(link.spm_req), .lock_bits(lock_bits),
		.fuse_low_byte(fuse_low_byte), .fuse_high_byte(fuse_high_byte),
		.fuse_extended_byte(fuse_extended_byte), .eeprom_write_busy(eeprom_write_busy));
	// clock
	initial begin
		forever #50 ref_clk = ~ref_clk;
	end
	// answer capture, pulse and busy tally, hang guard
	always @(posedge ref_clk) begin
		cycles++;
		if (ans_valid === 1'b1) got = ans_data;
		go_seen = go_seen | {lock_write_go, flash_fill_go, flash_write_go, flash_erase_go};
		if (link.ctrl_rdata[0] === 1'b1) busy_cyc++;
		if (cycles == 5000) begin
			failures++;
			give_verdict();
		end
	end
	// ----
	// shared tasks
	// ----
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] seen);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one request through the cpu end, waits until both ends are idle
	task automatic issue(input logic st, input logic [7:0] c, input logic [15:0] p);
		int n;
		n = 0;
		@(negedge ref_clk);
		got = 8'hXX;
		go_seen = 4'h0;
		busy_cyc = 0;
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req_is_store <= st;
		req_ctrl <= c;
		req_ptr <= p;
		@(posedge ref_clk);
		req_valid <= 1'b0;
		@(negedge ref_clk);
		while ((req_busy !== 1'b0 || link.ctrl_rdata[0] !== 1'b0) && n < 60) begin
			@(negedge ref_clk);
			n++;
		end
		repeat (4) @(negedge ref_clk);
	endtask
	task automatic give_verdict();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_reset();
		@(negedge ref_clk);
		chk("ctrl", {8'h00, spm_pkg::CTRL_RESET}, {8'h00, link.ctrl_rdata});
	endtask
	// all four pointers, back to back, pair must clear each time
	task automatic t_readback();
		logic [7:0] e;
		for (int i = 0; i < 4; i++) begin
			issue(1'b0, {3'b000, spm_pkg::CMD_LOCK}, 16'(i));
			e = i == 0 ? fuse_low_byte : i == 1 ? {2'b11, lock_bits} :
				i == 2 ? fuse_extended_byte : fuse_high_byte;
			chk("readback", {8'h00, e}, {8'h00, got});
			chk("pair", 16'h0000, {12'h000, link.ctrl_rdata[3:0]});
		end
	endtask
	// no pair, an invalid pattern, and an eeprom write in progress
	task automatic t_plain();
		@(posedge ref_clk);
		flash_byte <= 8'h96;
		issue(1'b0, 8'h00, spm_pkg::PTR_LOCK);
		chk("plain", 16'h0096, {8'h00, got});
		issue(1'b0, 8'h0B, spm_pkg::PTR_LOCK);
		chk("bad pattern", 16'h0096, {8'h00, got});
		@(posedge ref_clk);
		eeprom_write_busy <= 1'b1;
		issue(1'b0, {3'b000, spm_pkg::CMD_LOCK}, spm_pkg::PTR_FUSE_LOW);
		chk("eeprom busy", 16'h0096, {8'h00, got});
		@(posedge ref_clk);
		eeprom_write_busy <= 1'b0;
		// a fill command with no store: the store window runs out
		issue(1'b0, {3'b000, spm_pkg::CMD_FILL}, 16'h0010);
		chk("fill then load", 16'h0096, {8'h00, got});
		chk("fill unused", 16'h0000, {15'h0000, go_seen[2]});
		chk("store window", 16'h0000, {12'h000, link.ctrl_rdata[3:0]});
	endtask
	task automatic t_boot();
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk);
			{boot_size_sel_1, boot_size_sel_0} <= 2'(3 - i);
			repeat (3) @(negedge ref_clk);
			chk("boot start", 16'h4000 - (16'h0100 << i), {2'b00, boot_start_addr});
		end
	endtask
	// erase in the top region, a buffer fill and a lock write
	task automatic t_store();
		issue(1'b1, {3'b000, spm_pkg::CMD_ERASE}, 16'h7080);
		chk("erase go", 16'h0001, {15'h0000, go_seen[0]});
		chk("page", 16'h00E1, {8'h00, page_number_field});
		chk("blocking", 16'h0001, {15'h0000, in_blocking_region});
		chk("write time", 16'h0001, {15'h0000, busy_cyc >= 8});
		issue(1'b1, {3'b000, spm_pkg::CMD_WRITE}, 16'h0100);
		chk("write go", 16'h0001, {15'h0000, go_seen[1]});
		chk("write page", 16'h0002, {8'h00, page_number_field});
		chk("concurrent", 16'h0000, {15'h0000, in_blocking_region});
		chk("section busy", 16'h0001, {15'h0000, link.ctrl_rdata[6]});
		issue(1'b1, {3'b000, spm_pkg::CMD_REEN}, 16'h0000);
		chk("section free", 16'h0000, {15'h0000, link.ctrl_rdata[6]});
		issue(1'b1, {3'b000, spm_pkg::CMD_FILL}, 16'h0046);
		chk("fill go", 16'h0001, {15'h0000, go_seen[2]});
		chk("word", 16'h0023, {10'h000, word_in_page_field});
		@(posedge ref_clk);
		req_r0 <= 8'h15;
		issue(1'b1, {3'b000, spm_pkg::CMD_LOCK}, spm_pkg::PTR_LOCK);
		chk("lock go", 16'h0001, {15'h0000, go_seen[3]});
		chk("lock data", 16'h00D5, {8'h00, lock_write_data});
	endtask
	// a reset in the middle of a blocking erase must not cut the erase short
	task automatic t_reset_write();
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req_is_store <= 1'b1;
		req_ctrl <= {3'b000, spm_pkg::CMD_ERASE};
		req_ptr <= 16'h7080;
		@(posedge ref_clk);
		req_valid <= 1'b0;
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk);
		chk("halt", 16'h0001, {15'h0000, link.cpu_halt});
		@(posedge ref_clk);
		srst <= 1'b1;
		@(posedge ref_clk);
		srst <= 1'b0;
		repeat (2) @(negedge ref_clk);
		chk("write kept", 16'h0001, {15'h0000, link.ctrl_rdata[0]});
		repeat (12) @(negedge ref_clk);
		chk("write ended", 16'h0000, {15'h0000, link.ctrl_rdata[0]});
	endtask
	// main sequence
	initial begin
		repeat (5) @(posedge ref_clk);
		srst <= 1'b0;
		t_reset();
		t_readback();
		t_plain();
		t_boot();
		t_store();
		t_reset_write();
		give_verdict();
	end
endmodule
